// ### logic/sad_datapath.v
// Sliced ALU datapath: 56-bit ALU (high, low, ext, float sections),
// leg multiplexers, data and stage registers, shifter slice transport.
// Assumes stage edges are one-cycle enables from the pipeline controller on sys_clk.
`timescale 1ns/1ps
`include "sad_defines.vh"

// Operation
// - Arithmetic select codes decode to divide, increments, add, subtracts, decrements.
// - Code 06 is undefined; it yields zeros here.
// - Look-ahead carry spans 56 bits, grouped by carry selects as 16/32/48/56.
// - High and low take two carry selects, ext one, float none.
// - Each section gives true and inverted result, sign, nibble/byte carries, zero.
// - Two A selects pick regfile, stage register, emit or carry-save carry.
// - Three B selects pick emit, data, carry-save sum, latched bus B, slice input.
// - Bus B latch opens at stage 7, closes by stage 8; driver holds data.
// - Slice input: pack data high, registered emit low, cc/parity ext, guard float.
// - Stage register captures shifter output at stage 9, selectable onto A leg.
// - Read right after write of same location takes the stage register.
// - Result saved at end of stage 9, written to regfile at end of stage 10.
// - Three stage registers: internal, bus D copy, regfile write copy.
// - Data register loads shifter or ALU output, feeds B, collects quotient.
// - Shifter is three 16-bit slices, each seeing all 48 bits, strapped by part.
// - Divide select swaps add and subtract-A, only when mode code is 00.
// - Mode selects per section, registered at stage 7.
module sad_datapath (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        stage7_edge,
	input  wire        stage8_edge,
	input  wire        stage9_edge,
	input  wire        stage10_edge,
	input  wire [19:0] mode_select,
	input  wire        divide_select,
	input  wire [1:0]  carry_sel_high,
	input  wire [1:0]  carry_sel_low,
	input  wire        carry_sel_ext,
	input  wire [7:0]  a_leg_select,
	input  wire [11:0] b_leg_select,
	input  wire [55:0] regfile_output,
	input  wire [55:0] emit,
	input  wire [55:0] csa_carry_register,
	input  wire [55:0] csa_sum_register,
	input  wire [15:0] bus_b_high_data,
	input  wire [15:0] pack_data,
	input  wire [15:0] cc_parity_data,
	input  wire [2:0]  guard_bits,
	input  wire        bypass_hit8,
	input  wire        bypass_hit7,
	input  wire        data_reg_load,
	input  wire        data_src_alu,
	input  wire        rf_write_request,
	output reg  [55:0] alu_result,
	output reg  [55:0] alu_result_n,
	output reg  [3:0]  result_sign,
	output reg  [7:0]  nibble_byte_carry_out,
	output reg  [3:0]  zero_detect_flag,
	output reg  [47:0] bus_d_stage,
	output reg  [47:0] rf_write_stage,
	output reg         rf_write_strobe
);

// ----------------------------------------
// Functions
// ----------------------------------------
function [9:0] mode_decode;
	input [4:0] mode;
	input       div;
	begin
		case (mode)
			5'h00: mode_decode = div ? {`SAD_OP_ADD, `SAD_OP_ADD} : {`SAD_OP_SUBTRACT_A, `SAD_OP_SUBTRACT_A};
			5'h01: mode_decode = {`SAD_OP_INCREMENT_A, `SAD_OP_INCREMENT_A};
			5'h02: mode_decode = {`SAD_OP_ADD, `SAD_OP_ADD};
			5'h03: mode_decode = {`SAD_OP_SUBB, `SAD_OP_DECA};
			5'h04: mode_decode = {`SAD_OP_SUBTRACT_A, `SAD_OP_SUBTRACT_A};
			5'h05: mode_decode = {`SAD_OP_ZERO, `SAD_OP_ADD};
			5'h06: mode_decode = {`SAD_OP_ZERO, `SAD_OP_ZERO};
			5'h07: mode_decode = {`SAD_OP_SUBB, `SAD_OP_SUBB};
			5'h08: mode_decode = {`SAD_OP_NOTA, `SAD_OP_NOTA};
			5'h09: mode_decode = {`SAD_OP_INCREMENT_A, `SAD_OP_INCREMENT_A};
			5'h0a: mode_decode = {`SAD_OP_INCREMENT_A, `SAD_OP_ADD};
			5'h0b: mode_decode = {`SAD_OP_DECA, `SAD_OP_DECA};
			5'h0c: mode_decode = {`SAD_OP_DECB, `SAD_OP_DECB};
			5'h0d: mode_decode = {`SAD_OP_ZERO, `SAD_OP_INCB};
			5'h0e: mode_decode = {`SAD_OP_INCB, `SAD_OP_INCB};
			5'h0f: mode_decode = {`SAD_OP_NOTB, `SAD_OP_NOTB};
			5'h10: mode_decode = {`SAD_OP_OR, `SAD_OP_OR};
			5'h11: mode_decode = {`SAD_OP_TA, `SAD_OP_ZERO};
			5'h12: mode_decode = {`SAD_OP_AND, `SAD_OP_AND};
			5'h13: mode_decode = {`SAD_OP_OR, `SAD_OP_TA};
			5'h14: mode_decode = {`SAD_OP_XOR, `SAD_OP_XOR};
			5'h15: mode_decode = {`SAD_OP_ZERO, `SAD_OP_TB};
			5'h16: mode_decode = {`SAD_OP_ANDNB, `SAD_OP_ANDNB};
			5'h17: mode_decode = {`SAD_OP_NANDB, `SAD_OP_NANDB};
			5'h18: mode_decode = {`SAD_OP_TA, `SAD_OP_TA};
			5'h19: mode_decode = {`SAD_OP_TA, `SAD_OP_TB};
			5'h1a: mode_decode = {`SAD_OP_TB, `SAD_OP_TA};
			5'h1b: mode_decode = {`SAD_OP_ZERO, `SAD_OP_TA};
			5'h1c: mode_decode = {`SAD_OP_TB, `SAD_OP_TB};
			5'h1d: mode_decode = {`SAD_OP_ZERO, `SAD_OP_ZERO};
			5'h1e: mode_decode = {`SAD_OP_TB, `SAD_OP_ZERO};
			default: mode_decode = {`SAD_OP_ONES, `SAD_OP_ONES};
		endcase
	end
endfunction

// Forced carry-in for the bottom nibble of a group
function carry_const;
	input [4:0] op;
	begin
		carry_const = (op == `SAD_OP_SUBTRACT_A) || (op == `SAD_OP_SUBB) ||
			(op == `SAD_OP_INCREMENT_A) || (op == `SAD_OP_INCB);
	end
endfunction

// Returns {carry, result} for one nibble
function [4:0] nibble_op;
	input [4:0] op;
	input [3:0] a;
	input [3:0] b;
	input       cin;
	begin
		case (op)
			`SAD_OP_ADD:   nibble_op = {1'b0, a} + {1'b0, b} + {4'h0, cin};
			`SAD_OP_SUBTRACT_A:  nibble_op = {1'b0, b} + {1'b0, ~a} + {4'h0, cin};
			`SAD_OP_SUBB:  nibble_op = {1'b0, a} + {1'b0, ~b} + {4'h0, cin};
			`SAD_OP_INCREMENT_A:  nibble_op = {1'b0, a} + {4'h0, cin};
			`SAD_OP_DECA:  nibble_op = {1'b0, a} + 5'h0f + {4'h0, cin};
			`SAD_OP_INCB:  nibble_op = {1'b0, b} + {4'h0, cin};
			`SAD_OP_DECB:  nibble_op = {1'b0, b} + 5'h0f + {4'h0, cin};
			`SAD_OP_ONES:  nibble_op = 5'h0f;
			`SAD_OP_TA:    nibble_op = {1'b0, a};
			`SAD_OP_TB:    nibble_op = {1'b0, b};
			`SAD_OP_NOTA:  nibble_op = {1'b0, ~a};
			`SAD_OP_NOTB:  nibble_op = {1'b0, ~b};
			`SAD_OP_OR:    nibble_op = {1'b0, a | b};
			`SAD_OP_AND:   nibble_op = {1'b0, a & b};
			`SAD_OP_XOR:   nibble_op = {1'b0, a ^ b};
			`SAD_OP_ANDNB: nibble_op = {1'b0, a & ~b};
			`SAD_OP_NANDB: nibble_op = {1'b0, ~a & b};
			default:       nibble_op = 5'h00;
		endcase
	end
endfunction

// A leg: bypass steers a regfile read onto the stage register
function [15:0] a_leg_mux;
	input [1:0]  sel;
	input [15:0] rf;
	input [15:0] rs;
	input [15:0] em;
	input [15:0] cr;
	input        hit;
	begin
		case (sel)
			`SAD_ASEL_REGFILE: a_leg_mux = hit ? rs : rf;
			`SAD_ASEL_STAGE:   a_leg_mux = rs;
			`SAD_ASEL_EMIT:    a_leg_mux = em;
			default:           a_leg_mux = cr;
		endcase
	end
endfunction

function [15:0] b_leg_mux;
	input [2:0]  sel;
	input [15:0] em;
	input [15:0] rd;
	input [15:0] sm;
	input [15:0] bb;
	input [15:0] slice_specific_input;
	begin
		case (sel)
			`SAD_BSEL_EMIT:  b_leg_mux = em;
			`SAD_BSEL_DATA:  b_leg_mux = rd;
			`SAD_BSEL_SUM:   b_leg_mux = sm;
			`SAD_BSEL_BUSB:  b_leg_mux = bb;
			`SAD_BSEL_SLICE: b_leg_mux = slice_specific_input;
			default:         b_leg_mux = 16'h0000;
		endcase
	end
endfunction

// One shifter slice: sees all 48 bits, strap picks its part
function [15:0] shifter_slice_chip;
	input [47:0] all_bits;
	input [1:0]  strap;
	begin
		case (strap)
			`SAD_STRAP_HIGH: shifter_slice_chip = all_bits[47:32];
			`SAD_STRAP_LOW:  shifter_slice_chip = all_bits[31:16];
			default:         shifter_slice_chip = all_bits[15:0];
		endcase
	end
endfunction

// ----------------------------------------
// Stage 7 registered controls
// ----------------------------------------
reg [19:0] mode_reg;
reg        divide_reg;
reg [1:0]  csel_high;
reg [1:0]  csel_low;
reg        csel_ext;
reg [7:0]  a_sel_reg;
reg [11:0] b_sel_reg;
reg [15:0] emit_low_reg;
reg        bus_b_open;
reg [15:0] bus_b_latched;

always @(posedge sys_clk) begin
	if (reset) begin
		mode_reg      <= 20'h00000;
		divide_reg    <= 1'b0;
		csel_high     <= 2'h0;
		csel_low      <= 2'h0;
		csel_ext      <= 1'b0;
		a_sel_reg     <= 8'h00;
		b_sel_reg     <= 12'h000;
		emit_low_reg  <= 16'h0000;
		bus_b_open    <= 1'b0;
		bus_b_latched <= 16'h0000;
	end else begin
		if (stage7_edge) begin
			mode_reg     <= mode_select;
			divide_reg   <= divide_select;
			csel_high    <= carry_sel_high;
			csel_low     <= carry_sel_low;
			csel_ext     <= carry_sel_ext;
			a_sel_reg    <= a_leg_select;
			b_sel_reg    <= b_leg_select;
			emit_low_reg <= emit[39:24];
		end
		// Transparent while open, so the value seen last before close is kept
		if (stage7_edge)
			bus_b_open <= 1'b1;
		else if (stage8_edge)
			bus_b_open <= 1'b0;
		if (stage7_edge || bus_b_open)
			bus_b_latched <= bus_b_high_data;
	end
end

// ----------------------------------------
// Leg multiplexers
// ----------------------------------------
reg  [47:0] stage_register;
reg  [55:0] data_register;
wire [55:0] a_leg;
wire [55:0] b_leg;
wire [15:0] a_float;
wire [15:0] b_float;

assign a_leg[55:40] = a_leg_mux(a_sel_reg[7:6], regfile_output[55:40], stage_register[47:32],
	emit[55:40], csa_carry_register[55:40], bypass_hit8);
assign a_leg[39:24] = a_leg_mux(a_sel_reg[5:4], regfile_output[39:24], stage_register[31:16],
	emit[39:24], csa_carry_register[39:24], bypass_hit8);
assign a_leg[23:8]  = a_leg_mux(a_sel_reg[3:2], regfile_output[23:8], stage_register[15:0],
	emit[23:8], csa_carry_register[23:8], bypass_hit7);
// Float slice has no stage register or carry-save path on its A leg
assign a_float      = a_leg_mux(a_sel_reg[1:0], {8'h00, regfile_output[7:0]}, 16'h0000,
	{8'h00, emit[7:0]}, 16'h0000, 1'b0);
assign a_leg[7:0]   = a_float[7:0];

assign b_leg[55:40] = b_leg_mux(b_sel_reg[11:9], emit[55:40], data_register[55:40],
	csa_sum_register[55:40], bus_b_latched, pack_data);
assign b_leg[39:24] = b_leg_mux(b_sel_reg[8:6], emit[39:24], data_register[39:24],
	csa_sum_register[39:24], bus_b_latched, emit_low_reg);
assign b_leg[23:8]  = b_leg_mux(b_sel_reg[5:3], emit[23:8], data_register[23:8],
	csa_sum_register[23:8], bus_b_latched, cc_parity_data);
assign b_float      = b_leg_mux(b_sel_reg[2:0], {8'h00, emit[7:0]}, {8'h00, data_register[7:0]},
	{8'h00, csa_sum_register[7:0]}, {8'h00, bus_b_latched[7:0]}, {13'h0, guard_bits});
assign b_leg[7:0]   = b_float[7:0];

// ----------------------------------------
// ALU core with sectioned carry
// ----------------------------------------
reg [19:0] op_hi;
reg [19:0] op_lo;
reg [3:0]  chain;
reg [55:0] sum;
reg [13:0] nib_carry;
reg [6:0]  byte_carry;
reg [9:0]  dec;
reg [4:0]  lo_res;
reg [4:0]  hi_res;
reg        c;
integer    s;
integer    i;
integer    k;

always @* begin
	op_hi = 20'h00000;
	op_lo = 20'h00000;
	dec   = 10'h000;
	for (k = 0; k < 4; k = k + 1) begin
		dec = mode_decode(mode_reg[k*5 +: 5], divide_reg);
		op_hi[k*5 +: 5] = dec[9:5];
		op_lo[k*5 +: 5] = dec[4:0];
	end
	// A section takes its lower neighbour's carry only when grouped with it
	chain[`SAD_SEC_FLOAT] = 1'b0;
	chain[`SAD_SEC_EXT]   = csel_ext;
	chain[`SAD_SEC_LOW]   = csel_low[1];
	chain[`SAD_SEC_HIGH]  = (csel_high != `SAD_CSEL_16);
end

always @* begin
	sum        = 56'h0;
	nib_carry  = 14'h0;
	byte_carry = 7'h0;
	lo_res     = 5'h00;
	hi_res     = 5'h00;
	c          = 1'b0;
	s          = 0;
	for (i = 0; i < 7; i = i + 1) begin
		s = (i + 1) / 2;
		// A split byte must not inherit the neighbour's carry on its low nibble
		if (op_hi[s*5 +: 5] != op_lo[s*5 +: 5])
			c = carry_const(op_lo[s*5 +: 5]);
		else if (i == 0 || i == 1 || i == 3 || i == 5)
			c = chain[s] ? c : carry_const(op_lo[s*5 +: 5]);
		lo_res = nibble_op(op_lo[s*5 +: 5], a_leg[i*8 +: 4], b_leg[i*8 +: 4], c);
		// Split modes break the carry between nibbles
		c = (op_hi[s*5 +: 5] == op_lo[s*5 +: 5]) ? lo_res[4] : carry_const(op_hi[s*5 +: 5]);
		hi_res = nibble_op(op_hi[s*5 +: 5], a_leg[i*8+4 +: 4], b_leg[i*8+4 +: 4], c);
		c = hi_res[4];
		sum[i*8 +: 8]       = {hi_res[3:0], lo_res[3:0]};
		nib_carry[i*2 +: 2] = {hi_res[4], lo_res[4]};
		byte_carry[i]       = hi_res[4];
	end
end

// ----------------------------------------
// Section outputs
// ----------------------------------------
always @(posedge sys_clk) begin
	if (reset) begin
		alu_result            <= 56'h0;
		alu_result_n          <= {56{1'b1}};
		result_sign           <= 4'h0;
		nibble_byte_carry_out <= 8'h00;
		zero_detect_flag      <= 4'hf;
	end else begin
		alu_result   <= sum;
		alu_result_n <= ~sum;
		result_sign  <= {sum[55], sum[39], sum[23], sum[7]};
		nibble_byte_carry_out <= {byte_carry[6], nib_carry[12], byte_carry[4], nib_carry[8],
			byte_carry[2], nib_carry[4], byte_carry[0], nib_carry[0]};
		zero_detect_flag <= {sum[55:40] == 16'h0000, sum[39:24] == 16'h0000,
			sum[23:8] == 16'h0000, sum[7:0] == 8'h00};
	end
end

// ----------------------------------------
// Shifter, stage and data registers
// ----------------------------------------
// Shift modes are outside this block; slices transport their own part
wire [47:0] shifter_out;
reg         write_pending;

assign shifter_out = {shifter_slice_chip(alu_result[55:8], `SAD_STRAP_HIGH),
	shifter_slice_chip(alu_result[55:8], `SAD_STRAP_LOW),
	shifter_slice_chip(alu_result[55:8], `SAD_STRAP_EXT)};

always @(posedge sys_clk) begin
	if (reset) begin
		stage_register  <= 48'h0;
		bus_d_stage     <= 48'h0;
		rf_write_stage  <= 48'h0;
		data_register   <= 56'h0;
		write_pending   <= 1'b0;
		rf_write_strobe <= 1'b0;
	end else begin
		rf_write_strobe <= 1'b0;
		if (stage9_edge) begin
			stage_register <= shifter_out;
			bus_d_stage    <= shifter_out;
			rf_write_stage <= shifter_out;
			write_pending  <= rf_write_request;
		end else if (stage10_edge && write_pending) begin
			rf_write_strobe <= 1'b1;
			write_pending   <= 1'b0;
		end
		if (data_reg_load) begin
			// Divide shifts in a quotient bit: one when the remainder stays non-negative
			if (mode_reg[19:15] == `SAD_MODE_DIVIDE)
				data_register <= {data_register[54:0], ~alu_result[55]};
			else if (data_src_alu)
				data_register <= alu_result;
			else
				data_register <= {shifter_out, alu_result[7:0]};
		end
	end
end

endmodule // sad_datapath

// ### logic/sad_defines.vh
// Constants for the sliced ALU datapath: nibble operations, leg selects,
// shifter straps and section layout. Included by sad_datapath.v only.
`ifndef SAD_DEFINES_VH
`define SAD_DEFINES_VH

// ----------------------------------------
// Nibble operations
// ----------------------------------------
`define SAD_OP_ADD   5'h00
`define SAD_OP_SUBTRACT_A  5'h01
`define SAD_OP_SUBB  5'h02
`define SAD_OP_INCREMENT_A  5'h03
`define SAD_OP_DECA  5'h04
`define SAD_OP_INCB  5'h05
`define SAD_OP_DECB  5'h06
`define SAD_OP_ZERO  5'h07
`define SAD_OP_ONES  5'h08
`define SAD_OP_TA    5'h09
`define SAD_OP_TB    5'h0a
`define SAD_OP_NOTA  5'h0b
`define SAD_OP_NOTB  5'h0c
`define SAD_OP_OR    5'h0d
`define SAD_OP_AND   5'h0e
`define SAD_OP_XOR   5'h0f
`define SAD_OP_ANDNB 5'h10
`define SAD_OP_NANDB 5'h11

// ----------------------------------------
// Mode codes with special meaning
// ----------------------------------------
`define SAD_MODE_DIVIDE 5'h00

// ----------------------------------------
// Carry select codes (high and low sections)
// ----------------------------------------
`define SAD_CSEL_16 2'h0
`define SAD_CSEL_32 2'h1
`define SAD_CSEL_48 2'h2
`define SAD_CSEL_56 2'h3

// ----------------------------------------
// A-leg and B-leg select codes
// ----------------------------------------
`define SAD_ASEL_REGFILE 2'h0
`define SAD_ASEL_STAGE   2'h1
`define SAD_ASEL_EMIT    2'h2
`define SAD_ASEL_CARRY   2'h3
`define SAD_BSEL_EMIT    3'h0
`define SAD_BSEL_DATA    3'h1
`define SAD_BSEL_SUM     3'h2
`define SAD_BSEL_BUSB    3'h3
`define SAD_BSEL_SLICE   3'h4

// ----------------------------------------
// Shifter slice straps and section indices
// ----------------------------------------
`define SAD_STRAP_HIGH 2'h2
`define SAD_STRAP_LOW  2'h1
`define SAD_STRAP_EXT  2'h0
`define SAD_SEC_FLOAT  0
`define SAD_SEC_EXT    1
`define SAD_SEC_LOW    2
`define SAD_SEC_HIGH   3

`endif

// ### verification/sad_datapath_props.sv
// Checker for the sliced ALU datapath, bound to its top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module sad_datapath_props (
	input wire        sys_clk,
	input wire        reset,
	input wire        stage7_edge,
	input wire        stage9_edge,
	input wire        stage10_edge,
	input wire [19:0] mode_select,
	input wire [55:0] alu_result,
	input wire [55:0] alu_result_n,
	input wire [3:0]  result_sign,
	input wire [7:0]  nibble_byte_carry_out,
	input wire [3:0]  zero_detect_flag,
	input wire [47:0] bus_d_stage,
	input wire [47:0] rf_write_stage,
	input wire        rf_write_strobe
);
	// Shifter transport is the top 48 result bits
	wire [47:0] shifter_view = alu_result[55:8];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// ----------------------------------------
	// Result and flags
	// ----------------------------------------
	a_result_inverse: assert property (alu_result_n == ~alu_result)
		else $error("inverted result differs");
	a_sign_bits: assert property (
		result_sign == {alu_result[55], alu_result[39], alu_result[23], alu_result[7]})
		else $error("sign flags differ");
	a_zero_flags: assert property (
		zero_detect_flag == {alu_result[55:40] == 16'h0, alu_result[39:24] == 16'h0,
		alu_result[23:8] == 16'h0, alu_result[7:0] == 8'h0})
		else $error("zero flags differ");
	a_ones_mode: assert property (stage7_edge && mode_select == {4{5'h1f}} |-> ##2
		(alu_result == {56{1'b1}} && nibble_byte_carry_out == 8'h00))
		else $error("ones mode wrong");
	a_zero_mode: assert property (stage7_edge && mode_select == {4{5'h1d}} |-> ##2
		(alu_result == 56'h0 && zero_detect_flag == 4'hf))
		else $error("zero mode wrong");

	// ----------------------------------------
	// Stage registers and write strobe
	// ----------------------------------------
	a_stage_load: assert property (stage9_edge |=>
		(bus_d_stage == $past(shifter_view) && rf_write_stage == $past(shifter_view)))
		else $error("stage copies not loaded");
	a_stage_hold: assert property (!stage9_edge |=> $stable(bus_d_stage) && $stable(rf_write_stage))
		else $error("stage copies moved");
	a_strobe_pulse: assert property (rf_write_strobe |=> !rf_write_strobe)
		else $error("write strobe too long");
	a_strobe_cause: assert property (rf_write_strobe |->
		$past(stage10_edge) && !$past(stage9_edge) && $stable(rf_write_stage))
		else $error("write strobe without stage 10");
endmodule // sad_datapath_props

bind sad_datapath sad_datapath_props u_props (.sys_clk(sys_clk), .reset(reset), .stage7_edge(stage7_edge),
	.stage9_edge(stage9_edge), .stage10_edge(stage10_edge), .mode_select(mode_select), .alu_result(alu_result),
	.alu_result_n(alu_result_n), .result_sign(result_sign), .nibble_byte_carry_out(nibble_byte_carry_out),
	.zero_detect_flag(zero_detect_flag), .bus_d_stage(bus_d_stage), .rf_write_stage(rf_write_stage),
	.rf_write_strobe(rf_write_strobe));

// ### verification/sad_datapath_tb_top.sv
// Self-checking bench for the sliced ALU datapath.
// Assumes the datapath, its checker and the register file model are compiled first.
`timescale 1ns/1ps
module sad_datapath_tb_top;
	localparam [47:0]  STALE = 48'h5a5a_c3c3_0f0f;
	// Mode table {high nibble op, low nibble op}, code 31 first
	localparam [319:0] OPS = {10'h108, 10'h147, 10'h0e7, 10'h14a, 10'h0e9, 10'h149, 10'h12a, 10'h129,
		10'h231, 10'h210, 10'h0ea, 10'h1ef, 10'h1a9, 10'h1ce, 10'h127, 10'h1ad, 10'h18c, 10'h0a5, 10'h0e5,
		10'h0c6, 10'h084, 10'h060, 10'h063, 10'h16b, 10'h042, 10'h0e7, 10'h0e0, 10'h021, 10'h044, 10'h000,
		10'h063, 10'h021};
	localparam [19:0]  CSEL = {5'h1f, 5'h14, 5'h0a, 5'h00};
	localparam [223:0] CEXP = {56'h0002_0001_0001_00, 56'h0002_0001_0000_00, 56'h0002_0000_0000_00,
		56'h0001_0000_0000_00};
	reg         sys_clk = 1'b0, reset = 1'b1, divide_select = 1'b0, carry_sel_ext = 1'b1;
	reg         stage7_edge = 1'b0, stage8_edge = 1'b0, stage9_edge = 1'b0, stage10_edge = 1'b0;
	reg         bypass_hit8 = 1'b0, bypass_hit7 = 1'b0, data_reg_load = 1'b0, data_src_alu = 1'b1;
	reg         rf_write_request = 1'b0;
	reg  [19:0] mode_select = 20'h00000;
	reg  [1:0]  carry_sel_high = 2'h3, carry_sel_low = 2'h3;
	reg  [7:0]  a_leg_select = 8'haa;
	reg  [11:0] b_leg_select = 12'h492;
	reg  [55:0] emit = 56'h0, csa_carry_register = 56'h9e3d5b7c2148a6, csa_sum_register = 56'h0;
	reg  [15:0] bus_b_high_data = 16'h0, pack_data = 16'h6b29, cc_parity_data = 16'hd417;
	reg  [2:0]  guard_bits = 3'h5;
	wire [55:0] regfile_output, alu_result, alu_result_n;
	wire [3:0]  result_sign, zero_detect_flag;
	wire [7:0]  nibble_byte_carry_out;
	wire [47:0] bus_d_stage, rf_write_stage;
	wire        rf_write_strobe;
	integer     n_fail = 0, n_tests = 0, cycles = 0, j, c;

	sad_datapath DUT (.sys_clk(sys_clk), .reset(reset), .stage7_edge(stage7_edge), .stage8_edge(stage8_edge),
		.stage9_edge(stage9_edge), .stage10_edge(stage10_edge), .mode_select(mode_select),
		.divide_select(divide_select), .carry_sel_high(carry_sel_high), .carry_sel_low(carry_sel_low),
		.carry_sel_ext(carry_sel_ext), .a_leg_select(a_leg_select), .b_leg_select(b_leg_select),
		.regfile_output(regfile_output), .emit(emit), .csa_carry_register(csa_carry_register),
		.csa_sum_register(csa_sum_register), .bus_b_high_data(bus_b_high_data), .pack_data(pack_data),
		.cc_parity_data(cc_parity_data), .guard_bits(guard_bits), .bypass_hit8(bypass_hit8),
		.bypass_hit7(bypass_hit7), .data_reg_load(data_reg_load), .data_src_alu(data_src_alu),
		.rf_write_request(rf_write_request), .alu_result(alu_result), .alu_result_n(alu_result_n),
		.result_sign(result_sign), .nibble_byte_carry_out(nibble_byte_carry_out),
		.zero_detect_flag(zero_detect_flag), .bus_d_stage(bus_d_stage), .rf_write_stage(rf_write_stage),
		.rf_write_strobe(rf_write_strobe));
	sad_rf_model #(.STALE_WORD(STALE)) u_rf (.sys_clk(sys_clk), .reset(reset), .rf_write_strobe(rf_write_strobe),
		.rf_write_stage(rf_write_stage), .regfile_output(regfile_output));

	always #50 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Expectations, checks and access tasks
	// ----------------------------------------
	function [55:0] f(input [4:0] k, input [55:0] x, input [55:0] y);
		case (k)
			5'h00: f = x + y;
			5'h01: f = y - x;
			5'h02: f = x - y;
			5'h03: f = x + 56'h1;
			5'h04: f = x - 56'h1;
			5'h05: f = y + 56'h1;
			5'h06: f = y - 56'h1;
			5'h07: f = 56'h0;
			5'h08: f = ~56'h0;
			5'h09: f = x;
			5'h0a: f = y;
			5'h0b: f = ~x;
			5'h0c: f = ~y;
			5'h0d: f = x | y;
			5'h0e: f = x & y;
			5'h0f: f = x ^ y;
			5'h10: f = x & ~y;
			default: f = ~x & y;
		endcase
	endfunction

	// Split modes work per nibble, so no carry crosses a nibble
	function [55:0] expect_of(input [4:0] code, input [55:0] x, input [55:0] y);
		reg [9:0]  e;
		reg [55:0] r;
		integer    i;
		begin
			e = OPS[code*10 +: 10];
			expect_of = f(e[4:0], x, y);
			if (e[9:5] != e[4:0]) begin
				for (i = 0; i < 14; i = i + 1) begin
					r = f((i % 2) ? e[9:5] : e[4:0], {52'h0, x[i*4 +: 4]}, {52'h0, y[i*4 +: 4]});
					expect_of[i*4 +: 4] = r[3:0];
				end
			end
		end
	endfunction

	task check(input [55:0] got, input [55:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task tick(input integer n);
		repeat (n) @(posedge sys_clk) #1;
	endtask

	// Controls are taken at the stage 7 edge, result one edge later
	task go(input [55:0] exp, input [55:0] mask);
		begin
			stage7_edge = 1'b1;
			tick(1);
			stage7_edge = 1'b0;
			tick(1);
			check(alu_result & mask, exp & mask);
		end
	endtask

	task final_report;
		begin
			if (n_fail == 0 && n_tests > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 1000) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0t timeout", $time);
			final_report;
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		tick(12);
		check(alu_result_n, ~alu_result);
		check({alu_result[4:0], zero_detect_flag, rf_write_strobe}, 10'h01e);
		reset = 1'b0;
		for (j = 0; j < 2; j = j + 1) begin
			emit = j ? ~56'h0 : 56'h3ca5ff0f9671e8;
			csa_sum_register = j ? 56'h1 : 56'h5a0001f0c38f27;
			for (c = 0; c < 32; c = c + 1) begin
				mode_select = {4{c[4:0]}};
				if (c != 6) begin
					go(expect_of(c[4:0], emit, csa_sum_register), ~56'h0);
				end
			end
		end
		mode_select = 20'h0;
		divide_select = 1'b1;
		go(emit + csa_sum_register, ~56'h0);
		mode_select = {4{5'h04}};
		go(csa_sum_register - emit, ~56'h0);
		divide_select = 1'b0;
		emit = {16'h0001, 16'hffff, 16'hffff, 8'hff};
		csa_sum_register = {16'h0000, 16'h0001, 16'h0001, 8'h01};
		mode_select = {4{5'h02}};
		for (j = 0; j < 4; j = j + 1) begin
			{carry_sel_high, carry_sel_low, carry_sel_ext} = CSEL[j*5 +: 5];
			go(CEXP[j*56 +: 56], ~56'h0);
		end
		check(nibble_byte_carry_out, 8'h3f);
		mode_select = {5'h18, 5'h1c, 5'h1d, 5'h1f};
		go({emit[55:40], csa_sum_register[39:24], 24'h0000ff}, ~56'h0);
		mode_select = {4{5'h18}};
		a_leg_select = 8'hff;
		go({csa_carry_register[55:8], 8'h00}, ~56'h0);
		mode_select = {4{5'h1c}};
		b_leg_select = 12'h924;
		go({pack_data, emit[39:24], cc_parity_data, 5'h00, guard_bits}, ~56'h0);
		b_leg_select = 12'h6db;
		bus_b_high_data = 16'ha5c3;
		go({16'ha5c3, 40'h0}, {16'hffff, 40'h0});
		stage8_edge = 1'b1;
		tick(1);
		stage8_edge = 1'b0;
		// Driver lets go of bus B once the latch has closed
		bus_b_high_data = 16'h5a3c;
		tick(2);
		check(alu_result[55:40], 16'ha5c3);
		mode_select = {4{5'h18}};
		a_leg_select = 8'haa;
		emit = 56'h71c2e49b3ad605;
		go(emit, ~56'h0);
		{stage9_edge, rf_write_request, data_reg_load} = 3'h7;
		tick(1);
		{stage9_edge, rf_write_request, data_reg_load} = 3'h0;
		check({8'h0, bus_d_stage}, {8'h0, emit[55:8]});
		check({7'h0, rf_write_stage, rf_write_strobe}, {7'h0, emit[55:8], 1'b0});
		emit = ~emit;
		a_leg_select = 8'h55;
		go({~emit[55:8], 8'h00}, ~56'h0);
		mode_select = {4{5'h1c}};
		b_leg_select = 12'h249;
		go(~emit, ~56'h0);
		mode_select = {4{5'h18}};
		a_leg_select = 8'h00;
		bypass_hit8 = 1'b1;
		go({~emit[55:24], STALE[15:0], 8'h00}, ~56'h0);
		{bypass_hit8, bypass_hit7} = 2'h1;
		go({STALE[47:16], ~emit[23:8], 8'h00}, ~56'h0);
		bypass_hit7 = 1'b0;
		go({STALE, 8'h00}, ~56'h0);
		stage10_edge = 1'b1;
		tick(1);
		stage10_edge = 1'b0;
		check(rf_write_strobe, 1'b1);
		tick(1);
		check(rf_write_strobe, 1'b0);
		go({~emit[55:8], 8'h00}, ~56'h0);
		final_report;
	end
endmodule // sad_datapath_tb_top

// ### verification/sad_rf_model.sv
// Register file model on the far side of the datapath: one word.
// Assumes the write strobe and data come from the datapath on sys_clk.
`timescale 1ns/1ps
module sad_rf_model #(
	parameter [47:0] STALE_WORD = 48'h5a5a_c3c3_0f0f
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        rf_write_strobe,
	input  wire [47:0] rf_write_stage,
	output wire [55:0] regfile_output
);
	reg [47:0] rf_word;

	always @(posedge sys_clk) begin
		if (reset) begin
			rf_word <= STALE_WORD;
		end else if (rf_write_strobe) begin
			rf_word <= rf_write_stage;
		end
	end
	// Float byte has no regfile copy, so it reads zero
	assign regfile_output = {rf_word, 8'h00};
endmodule // sad_rf_model
